// >>> src/operating_mode_controller.sv
// mode controller: sleep, idle, active and limp home sequencing with serial access gating
`timescale 1ns/100ps
module operating_mode_controller (
    input  wire logic                          clk_i,
    input  wire logic                          reset_i,
    input  wire logic                          low_power_request_pin_n_i,
    input  wire logic                          direct_input_a_i,
    input  wire logic                          direct_input_b_i,
    input  wire logic                          logic_supply_undervoltage_i,
    input  wire logic                          analog_supply_undervoltage_i,
    input  wire logic [operating_mode_pkg::CH_W-1:0] channel_enable_bits_i,
    input  wire logic                          keep_active_bit_i,
    input  wire logic                          pwm_gen_a_enable_i,
    input  wire logic                          pwm_gen_b_enable_i,
    input  wire logic [operating_mode_pkg::CH_W-1:0] input_a_channel_map_i,
    input  wire logic [operating_mode_pkg::CH_W-1:0] input_b_channel_map_i,
    input  wire logic                          reset_command_i,
    input  wire logic                          spi_sclk_i,
    input  wire logic                          spi_cs_n_i,
    output operating_mode_pkg::mode_t          mode_o,
    output logic [1:0]                         mode_field_o,
    output logic                               power_on_o,
    output logic [operating_mode_pkg::CH_W-1:0] channel_drive_o,
    output logic                               register_reset_o,
    output logic                               channel_error_clear_o,
    output logic                               spi_transfer_enable_o,
    output logic                               spi_write_enable_o,
    output logic                               spi_sdo_oe_n_o,
    output logic                               spi_write_commit_o,
    output logic                               diagnosis_enable_o,
    output logic                               limp_status_load_o,
    output logic                               transmission_error_force_o
);
    import operating_mode_pkg::*;

    typedef struct packed {
        logic [SYNC_W-1:0]   s1;
        logic [SYNC_W-1:0]   s2;
        logic [SYNC_W-1:0]   s3;
        logic [SYNC_W-1:0]   filt;
        mode_t               mode;
        logic [SETTLE_W-1:0] settle;
        logic [CH_W-1:0]     drive;
        logic [1:0]          mode_field;
        logic                reg_reset;
        logic                err_clear;
        logic                xfer_en;
        logic                wr_en;
        logic                diag_en;
        logic                limp_load;
        logic                ter_force;
        logic                power_on;
    } main_state_t;

    typedef struct packed {
        logic [3:0] bit_cnt;
        logic       wa1;
        logic       wa2;
        logic       commit;
    } link_state_t;

    main_state_t q;
    main_state_t d;
    link_state_t lq;
    link_state_t ld;

    logic            sleep_n;
    logic            in_a;
    logic            in_b;
    logic            any_in;
    logic            vdd_uv;
    logic            vm_uv;
    logic            regs_held;
    logic [CH_W-1:0] en_eff;
    logic            act_eff;
    logic            pwm_eff;
    logic            request;
    logic            powered;
    logic            cs_fell;
    mode_t           nxt;
    logic [CH_W-1:0] raw_drive;

    function automatic logic [CH_W-1:0] mapped(input logic            a,
                                               input logic            b,
                                               input logic [CH_W-1:0] map_a,
                                               input logic [CH_W-1:0] map_b);
        mapped = ({CH_W{a}} & map_a) | ({CH_W{b}} & map_b);
    endfunction : mapped

    function automatic logic [1:0] field_of(input mode_t m);
        unique case (m)
            MODE_LIMP:   field_of = FIELD_LIMP;
            MODE_ACTIVE: field_of = FIELD_ACTIVE;
            MODE_SLEEP,
            MODE_IDLE:   field_of = FIELD_IDLE;
        endcase
    endfunction : field_of

    function automatic logic on_mode(input mode_t m);
        on_mode = (m == MODE_ACTIVE) || (m == MODE_LIMP);
    endfunction : on_mode

    always_comb begin
        d = q;
        // three stages; a lane changes only once stages two and three agree
        d.s1 = {spi_cs_n_i, analog_supply_undervoltage_i, logic_supply_undervoltage_i,
                direct_input_b_i, direct_input_a_i, low_power_request_pin_n_i};
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < SYNC_W; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.filt[i] = q.s3[i];
            end
        end

        sleep_n = q.filt[SY_SLEEP_N];
        in_a    = q.filt[SY_IN_A];
        in_b    = q.filt[SY_IN_B];
        vdd_uv  = q.filt[SY_VDD_UV];
        vm_uv   = q.filt[SY_VM_UV];
        any_in  = in_a | in_b;
        cs_fell = q.filt[SY_CS_N] & ~d.filt[SY_CS_N];

        // register contents are unusable while the logic supply is low, the sleep pin is low or in limp home
        regs_held = vdd_uv || (q.mode == MODE_LIMP) || !sleep_n;
        en_eff    = regs_held ? '0 : channel_enable_bits_i;
        act_eff   = !regs_held && keep_active_bit_i;
        pwm_eff   = !regs_held && (pwm_gen_a_enable_i || pwm_gen_b_enable_i);
        request   = any_in || (|en_eff) || pwm_eff;

        powered   = (!vdd_uv || !vm_uv) && (sleep_n || any_in);

        if (!powered) begin
            nxt = MODE_SLEEP;
        end else if (!sleep_n) begin
            nxt = any_in ? MODE_LIMP : MODE_SLEEP;
        end else begin
            unique case (q.mode)
                MODE_ACTIVE: begin
                    if (vdd_uv && !any_in) begin
                        nxt = MODE_IDLE;
                    end else if (act_eff || request) begin
                        nxt = MODE_ACTIVE;
                    end else begin
                        nxt = MODE_IDLE;
                    end
                end
                MODE_SLEEP,
                MODE_IDLE,
                MODE_LIMP: begin
                    nxt = request ? MODE_ACTIVE : MODE_IDLE;
                end
            endcase
        end
        d.mode = nxt;

        // transition time is added only when coming up from sleep or idle
        if (on_mode(nxt) && !on_mode(q.mode)) begin
            d.settle = SETTLE_W'(TRANSITION_CYCLES);
        end else if (!on_mode(nxt)) begin
            d.settle = '0;
        end else if (q.settle != '0) begin
            d.settle = q.settle - SETTLE_W'(1);
        end

        unique case (nxt)
            MODE_ACTIVE: begin
                // with the logic supply low the maps read as their defaults
                raw_drive = en_eff | mapped(in_a, in_b,
                                            vdd_uv ? DEFAULT_MAP_A : input_a_channel_map_i,
                                            vdd_uv ? DEFAULT_MAP_B : input_b_channel_map_i);
            end
            MODE_LIMP: begin
                raw_drive = mapped(in_a, in_b, DEFAULT_MAP_A, DEFAULT_MAP_B);
            end
            MODE_SLEEP,
            MODE_IDLE: begin
                raw_drive = '0;
            end
        endcase
        d.drive = (d.settle == '0) ? raw_drive : '0;

        d.reg_reset = (nxt == MODE_SLEEP) || vdd_uv || (nxt == MODE_LIMP)
                      || reset_command_i;
        d.err_clear = (nxt == MODE_SLEEP) || vdd_uv;
        d.xfer_en   = (nxt != MODE_SLEEP) && !vdd_uv;
        d.wr_en     = d.xfer_en && (nxt != MODE_LIMP);
        d.diag_en   = (nxt == MODE_ACTIVE) && (d.settle == '0);
        d.limp_load = (nxt == MODE_LIMP) && (q.mode != MODE_LIMP);
        d.mode_field = field_of(nxt);

        // entry wins over a command edge seen in the same cycle
        if (d.limp_load) begin
            d.ter_force = 1'b1;
        end else if (nxt != MODE_LIMP || (cs_fell && q.xfer_en)) begin
            d.ter_force = 1'b0;
        end

        d.power_on = !vdd_uv || !vm_uv;

        if (reset_i) begin
            d            = '0;
            d.filt       = SYNC_RESET;
            d.mode       = MODE_SLEEP;
            d.mode_field = FIELD_IDLE;
            d.reg_reset  = 1'b1;
            d.err_clear  = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        q <= d;
    end

    // serial clock side: the serial clock stops outside frames, so a deselect
    // clears the link state at once; the counter wraps by itself after the last bit
    always_comb begin
        ld         = lq;
        ld.wa1     = q.wr_en;
        ld.wa2     = lq.wa1;
        ld.bit_cnt = lq.bit_cnt + 4'h1;
        // write allowance is quasi-static, the host keeps off mode transitions
        ld.commit  = (lq.bit_cnt == LAST_BIT) && lq.wa2;
    end

    always_ff @(posedge spi_sclk_i or posedge spi_cs_n_i) begin
        if (spi_cs_n_i) begin
            lq <= '0;
        end else begin
            lq <= ld;
        end
    end

    assign mode_o                     = q.mode;
    assign mode_field_o               = q.mode_field;
    assign power_on_o                 = q.power_on;
    assign channel_drive_o            = q.drive;
    assign register_reset_o           = q.reg_reset;
    assign channel_error_clear_o      = q.err_clear;
    assign spi_transfer_enable_o      = q.xfer_en;
    assign spi_write_enable_o         = q.wr_en;
    assign spi_sdo_oe_n_o             = spi_cs_n_i || !q.xfer_en;
    assign spi_write_commit_o         = lq.commit;
    assign diagnosis_enable_o         = q.diag_en;
    assign limp_status_load_o         = q.limp_load;
    assign transmission_error_force_o = q.ter_force;

endmodule : operating_mode_controller

// >>> common/operating_mode_pkg.sv
// constants and types shared by the operating mode controller
// Function
// - logic supply undervoltage holds registers reset and refuses transfers; above it, up to 5MHz.
// - exactly four modes: sleep, idle, active and limp home.
// - transitions decided from sleep pin, input pins, enables, keep-active and PWM enables.
// - switch-on request outside active goes to active if sleep pin high, else limp.
// - already active or limp: nominal turn-on; otherwise add mode transition time first.
// - sleep keeps outputs off, registers reset and serial access refused.
// - idle keeps every output channel off whatever the supplies.
// - idle keeps registers and transfers usable only while logic supply is good.
// - idle disables all diagnosis.
// - idle keeps the per-channel error bits while logic supply is good.
// - power-up needs a supply and a high pin; power-on when either supply good.
// - sleep pin high plus any input high or any enable bit set enters active.
// - keep-active clear: back to idle once inputs low, enables and PWM enables clear.
// - keep-active set: stay active regardless of inputs and enables.
// - logic undervoltage in active moves to idle when all inputs are low.
// - any high input enters active even with both channel maps at zero.
// - active with logic undervoltage: input pin control only, registers reset, no serial.
// - sleep pin low with an input high enters limp home, driving its channel.
// - limp home answers serial reads but ignores every write.
// - limp entry sets undervoltage flag, mode field 01b, clears both open-load flags.
// - transmission error flag reads 1b on first command after limp entry.
// - limp keeps error and status monitor bits live, other registers at default.
// - limp drives only channels 2 and 3 from the input pins.
// - default mapping: first input to channel 2, second input to channel 3.
// - sleep pin low with all inputs low enters sleep.
// - reset command restores register defaults but leaves error bits alone.
package operating_mode_pkg;

    typedef enum logic [1:0] {
        MODE_SLEEP,
        MODE_IDLE,
        MODE_ACTIVE,
        MODE_LIMP
    } mode_t;

    localparam int          CH_W             = 8;
    localparam logic [7:0]  DEFAULT_MAP_A    = 8'h04;
    localparam logic [7:0]  DEFAULT_MAP_B    = 8'h08;

    localparam logic [1:0]  FIELD_IDLE       = 2'h0;
    localparam logic [1:0]  FIELD_LIMP       = 2'h1;
    localparam logic [1:0]  FIELD_ACTIVE     = 2'h2;

    // synchroniser lanes
    localparam int          SY_SLEEP_N       = 0;
    localparam int          SY_IN_A          = 1;
    localparam int          SY_IN_B          = 2;
    localparam int          SY_VDD_UV        = 3;
    localparam int          SY_VM_UV         = 4;
    localparam int          SY_CS_N          = 5;
    localparam int          SYNC_W           = 6;
    localparam logic [5:0]  SYNC_RESET       = 6'h38;

    localparam int          CLK_HZ           = 10_000_000;
    localparam int          TRANSITION_US    = 100;
    localparam int          TRANSITION_CYCLES = (TRANSITION_US * (CLK_HZ / 1_000_000) > 0)
                                               ? TRANSITION_US * (CLK_HZ / 1_000_000) : 1;
    localparam int          SETTLE_W         = $clog2(TRANSITION_CYCLES + 1);

    localparam int          FRAME_BITS       = 16;
    localparam logic [3:0]  LAST_BIT         = 4'hf;

endpackage : operating_mode_pkg

// >>> dv/operating_mode_monitor.sv
// concurrent checks on the mode controller ports
`timescale 1ns/100ps
module operating_mode_monitor
    import operating_mode_pkg::*;
(
    input wire logic                 clk_i,
    input wire logic                 reset_i,
    input wire logic                 low_power_request_pin_n_i,
    input wire logic                 logic_supply_undervoltage_i,
    input wire logic [CH_W-1:0]      channel_enable_bits_i,
    input wire logic                 keep_active_bit_i,
    input wire logic                 spi_cs_n_i,
    input wire operating_mode_pkg::mode_t mode_o,
    input wire logic [1:0]           mode_field_o,
    input wire logic [CH_W-1:0]      channel_drive_o,
    input wire logic                 register_reset_o,
    input wire logic                 spi_transfer_enable_o,
    input wire logic                 spi_write_enable_o,
    input wire logic                 spi_sdo_oe_n_o,
    input wire logic                 diagnosis_enable_o,
    input wire logic                 limp_status_load_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff reset_i;
    chk_sleep_all_off: assert property (mode_o == MODE_SLEEP |->
        channel_drive_o == 8'h00 && register_reset_o && !spi_transfer_enable_o)
        else $error("sleep mode not quiet");
    chk_idle_no_drive: assert property (mode_o == MODE_IDLE |->
        channel_drive_o == 8'h00 && !diagnosis_enable_o) else $error("idle mode drives");
    chk_limp_two_only: assert property (mode_o == MODE_LIMP |->
        (channel_drive_o & 8'hf3) == 8'h00 && !spi_write_enable_o
        && mode_field_o == FIELD_LIMP) else $error("limp mode outputs wrong");
    chk_limp_entry_load: assert property (mode_o == MODE_LIMP && $past(mode_o) != MODE_LIMP
        |-> ##[0:1] limp_status_load_o) else $error("limp entry without status load");
    chk_settle_hold: assert property ($past(mode_o) inside {MODE_IDLE, MODE_SLEEP}
        && mode_o == MODE_ACTIVE |-> (channel_drive_o == 8'h00)[*8])
        else $error("channel on before transition time");
    chk_leave_off: assert property ($past(mode_o) inside {MODE_ACTIVE, MODE_LIMP}
        && mode_o inside {MODE_IDLE, MODE_SLEEP} |-> channel_drive_o == 8'h00)
        else $error("drive not cut on mode exit");
    chk_uv_serial_off: assert property (logic_supply_undervoltage_i[*8]
        |=> !spi_transfer_enable_o && register_reset_o) else $error("serial live in undervoltage");
    chk_cs_high_quiet: assert property (spi_cs_n_i |-> spi_sdo_oe_n_o)
        else $error("data out driven while deselected");
    chk_keep_active: assert property ((mode_o == MODE_ACTIVE && keep_active_bit_i
        && low_power_request_pin_n_i && !logic_supply_undervoltage_i)[*5] |=> mode_o == MODE_ACTIVE)
        else $error("left active with keep-active set");
    chk_enable_wakes: assert property ((low_power_request_pin_n_i
        && !logic_supply_undervoltage_i)[*5] ##0 (mode_o == MODE_IDLE && |channel_enable_bits_i)
        |=> mode_o == MODE_ACTIVE) else $error("enable bit did not wake");
endmodule : operating_mode_monitor

// >>> dv/spi_host_model.sv
// host serial master: one 16-bit frame per start edge, clock still outside frames
`timescale 1ns/100ps
module spi_host_model (
    input  wire logic start_i,
    input  wire logic commit_i,
    output logic      sclk_o,
    output logic      cs_n_o,
    output int        commits_o
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b0;
        commits_o = 0;
        // an early deselect edge clears the link state before the first frame
        #1 cs_n_o = 1'b1;
    end
    always @(posedge commit_i) commits_o++;
    // long lead-in so the slow side surely sees chip select low
    always @(posedge start_i) begin
        #1.7 cs_n_o = 1'b0;
        #350;
        repeat (16) begin
            #3 sclk_o = 1'b1;
            #3 sclk_o = 1'b0;
        end
        #3 cs_n_o = 1'b1;
    end
endmodule : spi_host_model

// >>> dv/tb_operating_mode_controller.sv
// self-checking bench for the operating mode controller
`timescale 1ns/100ps
module tb_operating_mode_controller;
    import operating_mode_pkg::*;
    logic clk_i = 0, reset_i = 1, sl_n = 0, in_a = 0, in_b = 0, uv = 0, auv = 0;
    logic keep = 0, pw_a = 0, pw_b = 0, rcmd = 0, start = 0;
    logic [7:0] en = 8'h00, ma = 8'h04, mb = 8'h08, r, drv;
    mode_t mode;
    logic [1:0] field;
    logic pwr, rr, eclr, xfer, wr, oe_n, commit, diag, load, transmission_error_flag, sclk, cs_n;
    int commits, n_errors = 0, n_checks = 0, cycles = 0;
    operating_mode_controller operating_mode_controller_i (
        .clk_i(clk_i), .reset_i(reset_i), .low_power_request_pin_n_i(sl_n),
        .direct_input_a_i(in_a), .direct_input_b_i(in_b), .logic_supply_undervoltage_i(uv),
        .analog_supply_undervoltage_i(auv), .channel_enable_bits_i(en), .keep_active_bit_i(keep),
        .pwm_gen_a_enable_i(pw_a), .pwm_gen_b_enable_i(pw_b), .input_a_channel_map_i(ma),
        .input_b_channel_map_i(mb), .reset_command_i(rcmd), .spi_sclk_i(sclk),
        .spi_cs_n_i(cs_n), .mode_o(mode), .mode_field_o(field), .power_on_o(pwr),
        .channel_drive_o(drv), .register_reset_o(rr), .channel_error_clear_o(eclr),
        .spi_transfer_enable_o(xfer), .spi_write_enable_o(wr), .spi_sdo_oe_n_o(oe_n),
        .spi_write_commit_o(commit), .diagnosis_enable_o(diag), .limp_status_load_o(load),
        .transmission_error_force_o(transmission_error_flag));
    spi_host_model spi_host_model_i (.start_i(start), .commit_i(commit), .sclk_o(sclk),
        .cs_n_o(cs_n), .commits_o(commits));
    initial forever #50 clk_i = ~clk_i;
    function automatic logic [7:0] exp_drv(logic [7:0] e, x, y, logic a, b);
        return e | ({8{a}} & x) | ({8{b}} & y);
    endfunction : exp_drv
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic go(int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : go
    // frames only in settled modes, never across an active/limp change
    task automatic frame();
        @(posedge clk_i);
        start <= 1'b1;
        @(posedge clk_i);
        start <= 1'b0;
        go(10);
    endtask : frame
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(75022));
        r = 8'($urandom_range(255, 1));
        go(16);
        @(posedge clk_i) reset_i <= 1'b0;
        go(8);
        chk("sleep", MODE_SLEEP, mode);
        chk("sleep regs", 1, rr);
        @(posedge clk_i) begin en <= r; in_a <= 1'b1; end
        go(1010);
        chk("limp", MODE_LIMP, mode);
        chk("limp drive", 8'h04, drv);
        chk("limp ter", 1, transmission_error_flag);
        frame();
        chk("ter after cmd", 0, transmission_error_flag);
        chk("limp writes", 0, commits);
        @(posedge clk_i) in_b <= 1'b1;
        go(6);
        chk("limp both", 8'h0c, drv);
        @(posedge clk_i) begin ma <= 8'($urandom); mb <= 8'($urandom); sl_n <= 1'b1; end
        go(6);
        chk("wake active", MODE_ACTIVE, mode);
        chk("active drive", exp_drv(en, ma, mb, 1, 1), drv);
        chk("power on", 1, pwr);
        chk("active field", FIELD_ACTIVE, field);
        frame();
        chk("active write", 1, commits);
        @(posedge clk_i) begin en <= 8'h00; in_a <= 1'b0; in_b <= 1'b0; end
        go(6);
        chk("back idle", MODE_IDLE, mode);
        chk("idle serial", 1, xfer);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_i) begin pw_a <= (i == 0); pw_b <= (i == 1); end
            go(3);
            chk("pwm wake", MODE_ACTIVE, mode);
            @(posedge clk_i) begin pw_a <= 1'b0; pw_b <= 1'b0; end
            go(3);
            chk("pwm idle", MODE_IDLE, mode);
        end
        @(posedge clk_i) en <= r;
        go(500);
        chk("settling", 8'h00, drv);
        go(510);
        chk("settled", r, drv);
        chk("diag on", 1, diag);
        @(posedge clk_i) begin en <= 8'h00; keep <= 1'b1; end
        go(8);
        chk("keep active", MODE_ACTIVE, mode);
        @(posedge clk_i) begin uv <= 1'b1; in_a <= 1'b1; en <= r; end
        go(8);
        chk("uv pin only", 8'h04, drv);
        chk("uv serial", 0, xfer);
        @(posedge clk_i) in_a <= 1'b0;
        go(8);
        chk("uv idle", MODE_IDLE, mode);
        chk("uv regs", 1, rr);
        @(posedge clk_i) begin uv <= 1'b0; keep <= 1'b0; en <= 8'h00; ma <= 8'h00; mb <= 8'h00; end
        go(8);
        @(posedge clk_i) in_b <= 1'b1;
        go(6);
        chk("unmapped wake", MODE_ACTIVE, mode);
        @(posedge clk_i) rcmd <= 1'b1;
        go(1);
        chk("cmd regs", 1, rr);
        chk("cmd errors kept", 0, eclr);
        @(posedge clk_i) begin rcmd <= 1'b0; in_b <= 1'b0; uv <= 1'b1; auv <= 1'b1; end
        go(8);
        chk("no supply", 0, pwr);
        @(posedge clk_i) sl_n <= 1'b0;
        go(8);
        chk("sleep again", MODE_SLEEP, mode);
        wrap_up();
    end
endmodule : tb_operating_mode_controller
bind operating_mode_controller operating_mode_monitor operating_mode_monitor_i (.*);
